/* design/host_master_regs_pkg.sv */
// package for the host master control register bank
// assumes a 32-bit host target port decoded against a memory base address
package host_master_regs_pkg;

	// --------------------------------------------------------------
	// register offsets and fields
	// --------------------------------------------------------------
	localparam logic [11:0] OFF_SOFTWARE_RESET_CONTROL = 12'h000;
	localparam logic [11:0] OFF_INTERRUPT_ENABLE_MASK = 12'h004;
	localparam logic [11:0] OFF_EVENT_STATUS = 12'h008;
	localparam int SW_RESET_BIT = 15;
	localparam int NUM_EVENTS = 16;
	localparam int SYS_ERR_BIT = 0;
	localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic SW_RESET_RESET = 1'b0;
	localparam logic [31:0] TX_LINK_IDLE = 32'hFFFFFFFF;

	// --------------------------------------------------------------
	// carriers
	// --------------------------------------------------------------
	typedef struct packed {
		logic sel;
		logic wr;
		logic [3:0] byte_lane_en_n;
		logic [31:0] addr;
		logic [31:0] wdata;
	} host_req_t;

	// system error causes
	typedef struct packed {
		logic addr_parity_err;
		logic special_cycle_parity_err;
		logic master_abort_rcvd;
		logic target_abort_det;
	} sys_err_src_t;

	typedef struct packed {
		logic sw_reset;
		logic [15:0] irq_en;
		logic [15:0] status;
		logic [31:0] rdata;
		logic rvalid;
		logic host_irq_n;
		logic [31:0] tx_link_out;
		logic core_reset_n;
		logic standby;
	} regs_state_t;

endpackage

/* design/host_master_reset_irq_regs.sv */
// host master reset and interrupt enable register bank
// assumes single-cycle host target accesses already qualified by the host port
`timescale 1ns/1ps

module host_master_reset_irq_regs
	import host_master_regs_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [31:0] i_mem_base,
	input wire logic i_sel,
	input wire logic i_wr,
	input wire logic [3:0] i_byte_lane_en_n,
	input wire logic [31:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic [NUM_EVENTS-1:0] i_event,
	input wire logic [3:0] i_sys_err_src,
	input wire logic [31:0] i_tx_link_data,
	output logic [DATA_W-1:0] o_rdata,
	output logic o_rvalid,
	output logic o_host_irq_n,
	output logic [31:0] o_tx_link_out,
	output logic o_core_reset_n,
	output logic o_standby
);

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	host_req_t req;
	sys_err_src_t serr;
	logic [31:0] rel_addr;
	logic lanes_on;
	logic hit_rst;
	logic hit_en;
	logic hit_stat;
	logic [NUM_EVENTS-1:0] ev;
	regs_state_t state_reg;
	regs_state_t state_next;

	// access qualifiers
	logic rd_req;
	logic wr_req;
	logic wr_rst;
	logic wr_en;
	logic wr_stat;
	logic any_hit;
	logic sys_err_hit;

	// read words, clear mask and interrupt term
	logic [31:0] rst_word;
	logic [31:0] en_word;
	logic [31:0] stat_word;
	logic [NUM_EVENTS-1:0] stat_clr;
	logic irq_any;

	// named enable bits
	logic tx_underflow_irq_en;
	logic tx_complete_irq_en;
	logic tx_free_full_irq_en;
	logic tx_ready_read_irq_en;
	logic tx_free_write_irq_en;
	logic rx_ready_full_irq_en;
	logic rx_free_empty_irq_en;
	logic rx_ready_write_irq_en;
	logic rx_large_free_read_irq_en;
	logic rx_small_free_read_irq_en;
	logic rx_overrun_irq_en;
	logic rx_format_err_irq_en;
	logic rx_abort_irq_en;
	logic rx_checksum_err_irq_en;
	logic parity_err_irq_en;
	logic sys_err_irq_en;

	// named status flags
	logic tx_underflow_flag;
	logic tx_complete_flag;
	logic tx_free_full_flag;
	logic tx_ready_read_flag;
	logic tx_free_write_flag;
	logic rx_ready_full_flag;
	logic rx_free_empty_flag;
	logic rx_ready_write_flag;
	logic rx_large_free_read_flag;
	logic rx_small_free_read_flag;
	logic rx_overrun_flag;
	logic rx_format_err_flag;
	logic rx_abort_flag;
	logic rx_checksum_err_flag;
	logic parity_err_flag;
	logic sys_err_flag;

	// gather request fields
	assign req = '{sel: i_sel, wr: i_wr, byte_lane_en_n: i_byte_lane_en_n, addr: i_addr, wdata: 32'(i_wdata)};
	assign serr = i_sys_err_src;
	assign rel_addr = req.addr - i_mem_base;
	assign lanes_on = req.sel && (req.byte_lane_en_n != 4'hF);
	assign hit_rst = lanes_on && (rel_addr == {20'h00000, OFF_SOFTWARE_RESET_CONTROL});
	assign hit_en = lanes_on && (rel_addr == {20'h00000, OFF_INTERRUPT_ENABLE_MASK});
	assign hit_stat = lanes_on && (rel_addr == {20'h00000, OFF_EVENT_STATUS});

	// any of the four system error causes
	assign sys_err_hit = serr.addr_parity_err
		| serr.special_cycle_parity_err
		| serr.master_abort_rcvd
		| serr.target_abort_det;

	// system error collects four causes into event zero
	always_comb begin
		ev = i_event;
		ev[SYS_ERR_BIT] = i_event[SYS_ERR_BIT] | sys_err_hit;
	end

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	// read and write qualifiers of a taken access
	assign rd_req = lanes_on && !req.wr;
	assign wr_req = lanes_on && req.wr;
	assign wr_rst = wr_req && hit_rst;
	assign wr_en = wr_req && hit_en;
	assign wr_stat = wr_req && hit_stat;
	assign any_hit = hit_rst || hit_en || hit_stat;

	// write-one-to-clear mask for the status word
	assign stat_clr = wr_stat ? req.wdata[NUM_EVENTS-1:0] : {NUM_EVENTS{1'b0}};

	// ----------------------------------------------------------------
	// enable bits by name, most significant first
	// ----------------------------------------------------------------
	// unpack the enable word into its sixteen named bits
	assign {
		tx_underflow_irq_en,
		tx_complete_irq_en,
		tx_free_full_irq_en,
		tx_ready_read_irq_en,
		tx_free_write_irq_en,
		rx_ready_full_irq_en,
		rx_free_empty_irq_en,
		rx_ready_write_irq_en,
		rx_large_free_read_irq_en,
		rx_small_free_read_irq_en,
		rx_overrun_irq_en,
		rx_format_err_irq_en,
		rx_abort_irq_en,
		rx_checksum_err_irq_en,
		parity_err_irq_en,
		sys_err_irq_en
	} = state_reg.irq_en;

	// ----------------------------------------------------------------
	// status flags by name, most significant first
	// ----------------------------------------------------------------
	// unpack the status word into its sixteen named flags
	assign {
		tx_underflow_flag,
		tx_complete_flag,
		tx_free_full_flag,
		tx_ready_read_flag,
		tx_free_write_flag,
		rx_ready_full_flag,
		rx_free_empty_flag,
		rx_ready_write_flag,
		rx_large_free_read_flag,
		rx_small_free_read_flag,
		rx_overrun_flag,
		rx_format_err_flag,
		rx_abort_flag,
		rx_checksum_err_flag,
		parity_err_flag,
		sys_err_flag
	} = state_reg.status;

	// ----------------------------------------------------------------
	// interrupt combine
	// ----------------------------------------------------------------
	// each flag reaches the pin only through its own enable
	assign irq_any = (tx_underflow_flag & tx_underflow_irq_en)
		| (tx_complete_flag & tx_complete_irq_en)
		| (tx_free_full_flag & tx_free_full_irq_en)
		| (tx_ready_read_flag & tx_ready_read_irq_en)
		| (tx_free_write_flag & tx_free_write_irq_en)
		| (rx_ready_full_flag & rx_ready_full_irq_en)
		| (rx_free_empty_flag & rx_free_empty_irq_en)
		| (rx_ready_write_flag & rx_ready_write_irq_en)
		| (rx_large_free_read_flag & rx_large_free_read_irq_en)
		| (rx_small_free_read_flag & rx_small_free_read_irq_en)
		| (rx_overrun_flag & rx_overrun_irq_en)
		| (rx_format_err_flag & rx_format_err_irq_en)
		| (rx_abort_flag & rx_abort_irq_en)
		| (rx_checksum_err_flag & rx_checksum_err_irq_en)
		| (parity_err_flag & parity_err_irq_en)
		| (sys_err_flag & sys_err_irq_en);

	// ----------------------------------------------------------------
	// read words
	// ----------------------------------------------------------------
	// reset word: only the reset bit is defined, unused bits read zero
	always_comb begin
		rst_word = 32'h00000000;
		rst_word[SW_RESET_BIT] = state_reg.sw_reset;
	end

	// enable word, unused upper half reads zero
	assign en_word = {
		16'h0000,
		tx_underflow_irq_en,
		tx_complete_irq_en,
		tx_free_full_irq_en,
		tx_ready_read_irq_en,
		tx_free_write_irq_en,
		rx_ready_full_irq_en,
		rx_free_empty_irq_en,
		rx_ready_write_irq_en,
		rx_large_free_read_irq_en,
		rx_small_free_read_irq_en,
		rx_overrun_irq_en,
		rx_format_err_irq_en,
		rx_abort_irq_en,
		rx_checksum_err_irq_en,
		parity_err_irq_en,
		sys_err_irq_en
	};

	// status word, unused upper half reads zero
	assign stat_word = {
		16'h0000,
		tx_underflow_flag,
		tx_complete_flag,
		tx_free_full_flag,
		tx_ready_read_flag,
		tx_free_write_flag,
		rx_ready_full_flag,
		rx_free_empty_flag,
		rx_ready_write_flag,
		rx_large_free_read_flag,
		rx_small_free_read_flag,
		rx_overrun_flag,
		rx_format_err_flag,
		rx_abort_flag,
		rx_checksum_err_flag,
		parity_err_flag,
		sys_err_flag
	};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		// read answer defaults to silence
		state_next.rvalid = 1'b0;
		state_next.rdata = 32'h00000000;

		// reset bit: taken as a whole word, never cleared by itself
		if (wr_rst) begin
			state_next.sw_reset = req.wdata[SW_RESET_BIT];
		end

		// status: hardware sets win over software write-one-to-clear
		state_next.status = (state_reg.status & ~stat_clr) | ev;

		// engine registers back to defaults, host side stays alive
		if (state_reg.sw_reset) begin
			state_next.irq_en = IRQ_EN_RESET;
			state_next.status = STATUS_RESET;
		end else if (wr_en) begin
			state_next.irq_en = req.wdata[NUM_EVENTS-1:0];
		end

		// read answer, one cycle after the access
		if (rd_req && any_hit) begin
			state_next.rvalid = 1'b1;
			if (hit_rst) begin
				state_next.rdata = rst_word;
			end else if (hit_en) begin
				state_next.rdata = en_word;
			end else begin
				state_next.rdata = stat_word;
			end
		end else if (rd_req) begin
			state_next.rvalid = 1'b1; // unmapped reads return zero
		end

		// interrupt pin low while any enabled flag is set
		state_next.host_irq_n = ~irq_any;

		// link pins held high while the engine is in soft reset
		state_next.tx_link_out = state_next.sw_reset ? TX_LINK_IDLE : i_tx_link_data;

		// engine reset and standby follow the reset bit
		state_next.core_reset_n = ~state_next.sw_reset;
		state_next.standby = state_next.sw_reset;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			state_reg.sw_reset <= SW_RESET_RESET;
			state_reg.irq_en <= IRQ_EN_RESET;
			state_reg.status <= STATUS_RESET;
			state_reg.rdata <= 32'h00000000;
			state_reg.rvalid <= 1'b0;
			state_reg.host_irq_n <= 1'b1;
			state_reg.tx_link_out <= TX_LINK_IDLE;
			state_reg.core_reset_n <= 1'b0;
			state_reg.standby <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from flops
	assign o_rdata = DATA_W'(state_reg.rdata);
	assign o_rvalid = state_reg.rvalid;
	assign o_host_irq_n = state_reg.host_irq_n;
	assign o_tx_link_out = state_reg.tx_link_out;
	assign o_core_reset_n = state_reg.core_reset_n;
	assign o_standby = state_reg.standby;

endmodule

/* bench/host_master_regs_asserts.sv */
// checker for the host master register bank
// assumes binding to the bank top with one clock domain
`timescale 1ns/1ps
module host_master_regs_asserts
	import host_master_regs_pkg::*;
#(parameter int DATA_W = 32) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [31:0] i_mem_base,
	input wire logic i_sel,
	input wire logic i_wr,
	input wire logic [3:0] i_byte_lane_en_n,
	input wire logic [31:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic o_host_irq_n,
	input wire logic [31:0] o_tx_link_out,
	input wire logic o_core_reset_n,
	input wire logic o_standby
);
	// --------
	// properties
	// --------
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	wire hit0 = i_sel && i_wr && i_byte_lane_en_n != 4'hF && i_addr == i_mem_base;
	read_answer_a: assert property (i_sel && !i_wr && i_byte_lane_en_n != 4'hF |-> ##[1:2] o_rvalid)
		else $error("read not answered");
	no_answer_a: assert property (i_sel && (i_wr || i_byte_lane_en_n == 4'hF) |=> !o_rvalid)
		else $error("answer without read");
	unused_zero_a: assert property (o_rdata[31:16] == 16'h0000 && (o_rvalid || o_rdata == 32'h0))
		else $error("unused read bits set");
	link_high_a: assert property (!o_core_reset_n |-> o_tx_link_out == TX_LINK_IDLE)
		else $error("link not high in reset");
	standby_core_a: assert property (o_standby |-> !o_core_reset_n)
		else $error("standby outside reset");
	reset_enter_a: assert property (hit0 && i_wdata[15] |=> o_standby && !o_core_reset_n)
		else $error("soft reset not entered");
	reset_hold_a: assert property (o_standby && !hit0 |=> o_standby)
		else $error("soft reset cleared itself");
	reset_leave_a: assert property (hit0 && !i_wdata[15] |=> !o_standby)
		else $error("soft reset not left");
	irq_quiet_a: assert property (o_standby [*4] |-> o_host_irq_n)
		else $error("interrupt in soft reset");
	cover property (hit0 && i_wdata[15]);
	cover property (!o_host_irq_n);
	cover property (o_rvalid && o_rdata != 32'h0);
endmodule
bind host_master_reset_irq_regs host_master_regs_asserts #(.DATA_W(DATA_W)) chk (.*);

/* bench/host_model.sv */
// host bus model: one dword access per call
// assumes reads are answered by a valid pulse within two cycles
`timescale 1ns/1ps
module host_model (
	input wire logic i_clk,
	input wire logic i_rvalid,
	input wire logic [31:0] i_rdata,
	output logic o_sel = 1'b0,
	output logic o_wr = 1'b0,
	output logic [3:0] o_be_n = 4'hF,
	output logic [31:0] o_addr = 32'h0,
	output logic [31:0] o_wdata = 32'h0
);
	// released lines flip so stale values never match
	task automatic acc(input logic w, input logic [3:0] be, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic v);
		@(negedge i_clk);
		{o_sel, o_wr, o_be_n, o_addr, o_wdata} = {1'b1, w, be, a, d};
		@(negedge i_clk);
		{o_sel, o_addr, o_wdata} = {1'b0, ~a, ~d};
		v = 1'b0;
		rd = 32'h0;
		for (int i = 0; i < 2 && !w && !v; i++) begin
			if (i_rvalid === 1'b1) {v, rd} = {1'b1, i_rdata};
			else @(negedge i_clk);
		end
	endtask
endmodule

/* bench/host_master_reset_irq_regs_test.sv */
// bench for the host master register bank
// assumes the host model and events change at falling edges
`timescale 1ns/1ps
module host_master_reset_irq_regs_test;
	import host_master_regs_pkg::*;
	localparam logic [31:0] BASE = 32'h00100000;
	logic clk = 1'b0, i_nrst = 1'b0, sel, wr, rv, irq_n, core_n, stby, v;
	logic [15:0] ev = 16'h0, en;
	logic [3:0] se = 4'h0, be_n;
	logic [31:0] txd = 32'h12345678, addr, wd, rdat, tx, d;
	int miscompares = 0, checks = 0, b;
	initial forever #2 clk = ~clk;
	host_model host (.i_clk(clk), .i_rvalid(rv), .i_rdata(rdat), .o_sel(sel), .o_wr(wr), .o_be_n(be_n),
		.o_addr(addr), .o_wdata(wd));
	host_master_reset_irq_regs uut (.i_core_clk(clk), .i_nrst(i_nrst), .i_mem_base(BASE), .i_sel(sel), .i_wr(wr),
		.i_byte_lane_en_n(be_n), .i_addr(addr), .i_wdata(wd), .i_event(ev), .i_sys_err_src(se), .i_tx_link_data(txd),
		.o_rdata(rdat), .o_rvalid(rv), .o_host_irq_n(irq_n), .o_tx_link_out(tx), .o_core_reset_n(core_n),
		.o_standby(stby));
	// --------
	// helpers
	// --------
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic rd(input logic [3:0] be, input logic [11:0] o, input logic [31:0] e);
		host.acc(1'b0, be, BASE + o, 32'h0, d, v);
		check(32'(v), 32'(be != 4'hF));
		if (v) check(d, e);
	endtask
	task automatic put(input logic [3:0] be, input logic [11:0] o, input logic [31:0] x);
		host.acc(1'b1, be, BASE + o, x, d, v);
	endtask
	// --------
	// sequence
	// --------
	initial begin
		repeat (20) @(negedge clk);
		i_nrst = 1'b1;
		rd(4'h0, OFF_SOFTWARE_RESET_CONTROL, 32'h0);
		rd(4'h0, OFF_INTERRUPT_ENABLE_MASK, 32'h0);
		put(4'h7, OFF_INTERRUPT_ENABLE_MASK, 32'h0000A5C3);
		rd(4'h0, OFF_INTERRUPT_ENABLE_MASK, 32'h0000A5C3);
		put(4'hF, OFF_INTERRUPT_ENABLE_MASK, 32'h0000FFFF);
		rd(4'hF, OFF_INTERRUPT_ENABLE_MASK, 32'h0);
		put(4'h0, 12'h010, 32'h0000FFFF);
		rd(4'h0, 12'h010, 32'h0);
		rd(4'h0, OFF_INTERRUPT_ENABLE_MASK, 32'h0000A5C3);
		host.acc(1'b0, 4'h0, 32'h00000004, 32'h0, d, v);
		check(32'(v), 32'h1);
		check(d, 32'h0);
		// every event and every system error cause, enabled and masked
		for (int j = 0; j < 2; j++) begin
			en = j ? 16'h5A3C : 16'hA5C3;
			put(4'h0, OFF_INTERRUPT_ENABLE_MASK, {16'h0, en});
			for (int k = 0; k < 20; k++) begin
				b = k < 16 ? k : SYS_ERR_BIT;
				if (k < 16) ev[k] = 1'b1;
				else se[k-16] = 1'b1;
				@(negedge clk);
				{ev, se} = 20'h0;
				repeat (3) @(negedge clk);
				check(32'(irq_n), 32'(!en[b]));
				rd(4'h0, OFF_EVENT_STATUS, 32'h1 << b);
				put(4'h0, OFF_EVENT_STATUS, 32'h1 << b);
				repeat (3) @(negedge clk);
				check(32'(irq_n), 32'h1);
			end
		end
		put(4'h0, OFF_SOFTWARE_RESET_CONTROL, 32'h00008000);
		repeat (2) @(negedge clk);
		check({stby, core_n}, 2'b10);
		check(tx, TX_LINK_IDLE);
		rd(4'h0, OFF_SOFTWARE_RESET_CONTROL, 32'h00008000);
		rd(4'h0, OFF_INTERRUPT_ENABLE_MASK, 32'h0);
		repeat (5) @(negedge clk);
		check(32'(stby), 32'h1);
		put(4'h0, OFF_SOFTWARE_RESET_CONTROL, 32'h0);
		repeat (2) @(negedge clk);
		check({stby, core_n}, 2'b01);
		check(tx, txd);
		put(4'h0, OFF_SOFTWARE_RESET_CONTROL, 32'h00008000);
		i_nrst = 1'b0;
		repeat (2) @(negedge clk);
		i_nrst = 1'b1;
		repeat (2) @(negedge clk);
		check({stby, core_n}, 2'b01);
		rd(4'h0, OFF_SOFTWARE_RESET_CONTROL, 32'h0);
		conclude();
	end
endmodule
